// ---- hw/tic_pkg.sv ----
// Shared constants and types for the trap and interrupt control block.
// Assumes a 16-bit register port with word indices and one system clock.
package tic_pkg;

  // Register word size and index width of the register port.
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 2;

  // Register indices on the register port.
  localparam logic [1:0] OFS_TRAP_CONTROL   = 2'h0;
  localparam logic [1:0] OFS_GLOBAL_CONTROL = 2'h1;
  localparam logic [1:0] OFS_FLAG_WORD0     = 2'h2;
  localparam logic [1:0] OFS_PRIORITY       = 2'h3;

  // Field positions in interrupt_trap_control.
  localparam int unsigned BIT_NESTING_OFF  = 15;
  localparam int unsigned BIT_ACC_A_OVF    = 14;
  localparam int unsigned BIT_ACC_B_OVF    = 13;
  localparam int unsigned BIT_ACC_A_CAT    = 12;
  localparam int unsigned BIT_ACC_B_CAT    = 11;
  localparam int unsigned BIT_ACC_A_OVF_EN = 10;
  localparam int unsigned BIT_ACC_B_OVF_EN = 9;
  localparam int unsigned BIT_CAT_EN       = 8;
  localparam int unsigned BIT_BAD_SHIFT    = 7;
  localparam int unsigned BIT_DIVIDE_ZERO  = 6;
  localparam int unsigned BIT_DMA_FAULT    = 5;
  localparam int unsigned BIT_ARITH        = 4;
  localparam int unsigned BIT_ADDRESS      = 3;
  localparam int unsigned BIT_STACK        = 2;
  localparam int unsigned BIT_OSC          = 1;

  // Field positions in interrupt_global_control.
  localparam int unsigned BIT_ALT_VECTOR   = 15;
  localparam int unsigned BIT_TIMED_BLOCK  = 14;
  localparam int unsigned EXT_COUNT        = 3;

  // Field positions in interrupt_flag_word0.
  localparam int unsigned BIT_EXT0_REQUEST = 0;
  localparam int unsigned BIT_FLAG_UNUSED  = 15;

  // Field position and width of the CPU priority level.
  localparam int unsigned PRIO_W           = 3;

  // Writable and readable masks of trap control and flag word; global control mask covers only its polarity field.
  localparam logic [15:0] MASK_TRAP_CONTROL   = 16'hfffe;
  localparam logic [15:0] MASK_GLOBAL_CONTROL = 16'h0007;
  localparam logic [15:0] MASK_FLAG_WORD0     = 16'h7fff;

  // Reset values.
  localparam logic [15:0] RST_TRAP_CONTROL    = 16'h0000;
  localparam logic [15:0] RST_FLAG_WORD0      = 16'h0000;
  localparam logic [2:0]  RST_EDGE_POLARITY   = 3'h0;
  localparam logic [2:0]  RST_PRIORITY        = 3'h0;

  // Trap events that the core reports, one cycle each.
  typedef struct packed {
    logic acc_a_ovf;
    logic acc_b_ovf;
    logic acc_a_cat;
    logic acc_b_cat;
    logic bad_shift;
    logic divide_zero;
    logic dma_fault;
    logic address_fault;
    logic stack_fault;
    logic osc_fault;
  } tic_trap_event_t;

  // Register port request from the core.
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tic_reg_req_t;

endpackage

// ---- hw/tic_edge_detect.sv ----
// One external interrupt pin: three-stage synchroniser and edge detector.
// Assumes an asynchronous pin; a change counts when stages two and three agree.
`timescale 1ns/10ps
module tic_edge_detect (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic falling_i,
  output logic      edge_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic pulse;
  } tic_edge_state_t;

  tic_edge_state_t state;
  tic_edge_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // The settled level moves only once stages two and three agree.
  always_comb begin
    next_state       = state;
    next_state.s1    = pin_i;
    next_state.s2    = state.s1;
    next_state.s3    = state.s2;
    next_state.pulse = 1'b0;
    if ((state.s2 == state.s3) && (state.s3 != state.level)) begin
      next_state.level = state.s3;
      next_state.pulse = falling_i ? ~state.s3 : state.s3;
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign edge_o = state.pulse;

endmodule

// ---- hw/tic_sticky_flags.sv ----
// Bank of sticky request flags, set by hardware and written by software.
// Assumes set pulses and writes on the same clock; a set beats a clear.
`timescale 1ns/10ps
module tic_sticky_flags #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic [W-1:0] mask_i,
  output logic      [W-1:0] flags_o
);

  typedef struct packed {
    logic [W-1:0] flags;
  } tic_sticky_state_t;

  tic_sticky_state_t state;
  tic_sticky_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Software write replaces the flags, then any set in this cycle is added.
  always_comb begin
    next_state = state;
    if (wr_i) begin
      next_state.flags = wdata_i & mask_i;
    end
    next_state.flags = (next_state.flags | set_i) & mask_i;
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags_o = state.flags;

endmodule

// ---- hw/tic_trap_and_interrupt_control.sv ----
// Trap and interrupt control: trap status, global control, first flag word.
// Assumes the core drives the register port and trap events on clk_sys_i,
// peripherals pulse their requests on the same clock, external pins are async.
//
// Operation
// - Top bit of trap control is a read/write nesting-disable control.
// - Ordinary accumulator A and B overflow traps set their own flags.
// - Catastrophic overflow traps of A and B set their own flags.
// - Each accumulator overflow trap is raised only while its enable is set.
// - Catastrophic overflow traps need the single shared enable bit.
// - Invalid accumulator shift math trap sets the bad-shift flag.
// - Divide-by-zero math trap sets the divide-zero flag.
// - DMA controller error trap sets the DMA fault flag.
// - Any math error trap sets the general arithmetic flag.
// - Address error and stack error traps set their own flags.
// - Oscillator failure trap sets the oscillator fault flag.
// - Alternate vector select bit chooses alternate or default vector table.
// - Read-only bit shows while timed interrupt block is in effect.
// - External interrupt polarity one means falling edge, zero rising.
// - Unimplemented positions of all three registers read as zero.
// - A flag reads one once its source requested, zero before.
// - DMA channel 1 done at flag bit 14, channel 0 at bit 4.
// - Converter 1 done flag sits at flag bit 13.
// - UART A transmit flag at bit 12, receive flag at bit 11.
// - SPI A event flag at bit 10, error flag at bit 9.
// - Timer C flag at bit 8, timer B at 7, timer A at 3.
// - Compare channel 2 flag at bit 6, capture channel 2 at bit 5.
// - Compare ch1 at bit 2, capture ch1 at bit 1, ext 0 at bit 0.
// - Request flags stay set until software writes zero to them.
// - Priority level bits are read-only to software while nesting is off.
`timescale 1ns/10ps
module tic_trap_and_interrupt_control (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // Register port.
  input  wire logic [1:0]               reg_addr_i,
  input  wire logic [15:0]              reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [15:0]              reg_rdata_o,
  // Trap events from the core, one cycle each.
  input  wire tic_pkg::tic_trap_event_t trap_event_i,
  // Timed interrupt block level from the core.
  input  wire logic                     timed_irq_block_i,
  // Peripheral request pulses in flag word positions.
  input  wire logic                     dma_ch1_done_i,
  input  wire logic                     converter1_done_i,
  input  wire logic                     uart_a_tx_i,
  input  wire logic                     uart_a_rx_i,
  input  wire logic                     spi_a_event_i,
  input  wire logic                     spi_a_error_i,
  input  wire logic                     timer_c_i,
  input  wire logic                     timer_b_i,
  input  wire logic                     compare_ch2_i,
  input  wire logic                     capture_ch2_i,
  input  wire logic                     dma_ch0_done_i,
  input  wire logic                     timer_a_i,
  input  wire logic                     compare_ch1_i,
  input  wire logic                     capture_ch1_i,
  // External interrupt pins, asynchronous.
  input  wire logic [2:0]               ext_pin_i,
  // Control and event outputs.
  output logic                          nesting_off_o,
  output logic                          alt_vector_select_o,
  output logic [2:0]                    cpu_priority_level_o,
  output logic                          trap_o,
  output logic [2:0]                    ext_edge_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State of this module.

  typedef struct packed {
    logic        nesting_off;
    logic        acc_a_overflow_trap_en;
    logic        acc_b_overflow_trap_en;
    logic        catastrophic_trap_en;
    logic        alt_vector_select;
    logic        timed_irq_block_active;
    logic [2:0]  edge_polarity;
    logic [2:0]  cpu_priority_level;
    logic [15:0] rdata;
    logic        trap;
    logic [2:0]  ext_edge;
  } tic_ctrl_state_t;

  tic_ctrl_state_t state;
  tic_ctrl_state_t next_state;

  tic_pkg::tic_reg_req_t req;

  logic [15:0] trap_set;
  logic [15:0] trap_flags;
  logic [15:0] flag_set;
  logic [15:0] flag_word0;
  logic [2:0]  edge_hit;
  logic        trap_wr;
  logic        flag_wr;
  logic        acc_a_ovf_trap;
  logic        acc_b_ovf_trap;
  logic        acc_a_cat_trap;
  logic        acc_b_cat_trap;
  logic        math_trap;
  logic [15:0] trap_word;
  logic [15:0] global_word;
  logic [15:0] priority_word;

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  // Bundle the port into one request.
  assign req.addr  = reg_addr_i;
  assign req.wdata = reg_wdata_i;
  assign req.wr    = reg_wr_i;
  assign req.rd    = reg_rd_i;

  // Write strobes of the two sticky banks.
  assign trap_wr = req.wr && (req.addr == tic_pkg::OFS_TRAP_CONTROL);
  assign flag_wr = req.wr && (req.addr == tic_pkg::OFS_FLAG_WORD0);

  ////////////////////////////////////////////////////////////////////////////
  // Trap qualification.

  // Overflow traps are taken only while their enables are set.
  assign acc_a_ovf_trap = trap_event_i.acc_a_ovf && state.acc_a_overflow_trap_en;
  assign acc_b_ovf_trap = trap_event_i.acc_b_ovf && state.acc_b_overflow_trap_en;
  assign acc_a_cat_trap = trap_event_i.acc_a_cat && state.catastrophic_trap_en;
  assign acc_b_cat_trap = trap_event_i.acc_b_cat && state.catastrophic_trap_en;

  // Every math cause also marks the general arithmetic flag.
  assign math_trap = acc_a_ovf_trap | acc_b_ovf_trap | acc_a_cat_trap | acc_b_cat_trap
                   | trap_event_i.bad_shift | trap_event_i.divide_zero;

  // Set pulses of the trap status bits.
  always_comb begin
    trap_set                               = 16'h0000;
    trap_set[tic_pkg::BIT_ACC_A_OVF]       = acc_a_ovf_trap;
    trap_set[tic_pkg::BIT_ACC_B_OVF]       = acc_b_ovf_trap;
    trap_set[tic_pkg::BIT_ACC_A_CAT]       = acc_a_cat_trap;
    trap_set[tic_pkg::BIT_ACC_B_CAT]       = acc_b_cat_trap;
    trap_set[tic_pkg::BIT_BAD_SHIFT]       = trap_event_i.bad_shift;
    trap_set[tic_pkg::BIT_DIVIDE_ZERO]     = trap_event_i.divide_zero;
    trap_set[tic_pkg::BIT_DMA_FAULT]       = trap_event_i.dma_fault;
    trap_set[tic_pkg::BIT_ARITH]           = math_trap;
    trap_set[tic_pkg::BIT_ADDRESS]         = trap_event_i.address_fault;
    trap_set[tic_pkg::BIT_STACK]           = trap_event_i.stack_fault;
    trap_set[tic_pkg::BIT_OSC]             = trap_event_i.osc_fault;
  end

  // Trap status flags; the control bits in the same word live in the state.
  tic_sticky_flags #(
    .W (16)
  ) u_trap_flags (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .set_i     (trap_set),
    .wr_i      (trap_wr),
    .wdata_i   (req.wdata),
    .mask_i    (16'h78fe),
    .flags_o   (trap_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt edges.

  // One synchroniser and edge detector per external pin.
  generate
    for (genvar i = 0; i < tic_pkg::EXT_COUNT; i++) begin : g_ext
      tic_edge_detect u_edge (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (ext_pin_i[i]),
        .falling_i (state.edge_polarity[i]),
        .edge_o    (edge_hit[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // First interrupt flag word.

  // Each source pulse lands on its own flag position.
  always_comb begin
    flag_set                               = 16'h0000;
    flag_set[14]                           = dma_ch1_done_i;
    flag_set[13]                           = converter1_done_i;
    flag_set[12]                           = uart_a_tx_i;
    flag_set[11]                           = uart_a_rx_i;
    flag_set[10]                           = spi_a_event_i;
    flag_set[9]                            = spi_a_error_i;
    flag_set[8]                            = timer_c_i;
    flag_set[7]                            = timer_b_i;
    flag_set[6]                            = compare_ch2_i;
    flag_set[5]                            = capture_ch2_i;
    flag_set[4]                            = dma_ch0_done_i;
    flag_set[3]                            = timer_a_i;
    flag_set[2]                            = compare_ch1_i;
    flag_set[1]                            = capture_ch1_i;
    flag_set[tic_pkg::BIT_EXT0_REQUEST]    = edge_hit[0];
  end

  // Flags stay set until software writes zero over them.
  tic_sticky_flags #(
    .W (16)
  ) u_flag_word0 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .set_i     (flag_set),
    .wr_i      (flag_wr),
    .wdata_i   (req.wdata),
    .mask_i    (tic_pkg::MASK_FLAG_WORD0),
    .flags_o   (flag_word0)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read views of the registers.

  // Trap control word: control bits from the state, status from the bank.
  always_comb begin
    trap_word                                = trap_flags;
    trap_word[tic_pkg::BIT_NESTING_OFF]      = state.nesting_off;
    trap_word[tic_pkg::BIT_ACC_A_OVF_EN]     = state.acc_a_overflow_trap_en;
    trap_word[tic_pkg::BIT_ACC_B_OVF_EN]     = state.acc_b_overflow_trap_en;
    trap_word[tic_pkg::BIT_CAT_EN]           = state.catastrophic_trap_en;
    trap_word                                = trap_word & tic_pkg::MASK_TRAP_CONTROL;
  end

  // Global control word with its read-only timed block status.
  always_comb begin
    global_word                              = 16'h0000;
    global_word[tic_pkg::BIT_ALT_VECTOR]     = state.alt_vector_select;
    global_word[tic_pkg::BIT_TIMED_BLOCK]    = state.timed_irq_block_active;
    global_word[2:0]                         = state.edge_polarity;
  end

  // Priority level word in the low bits.
  always_comb begin
    priority_word                            = 16'h0000;
    priority_word[tic_pkg::PRIO_W-1:0]       = state.cpu_priority_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Control writes, read data capture and registered event outputs.
  always_comb begin
    next_state                        = state;
    next_state.timed_irq_block_active = timed_irq_block_i;
    next_state.trap                   = |trap_set;
    next_state.ext_edge               = edge_hit;
    next_state.rdata                  = 16'h0000;

    // Register writes.
    if (req.wr) begin
      case (req.addr)
        tic_pkg::OFS_TRAP_CONTROL: begin
          next_state.nesting_off            = req.wdata[tic_pkg::BIT_NESTING_OFF];
          next_state.acc_a_overflow_trap_en = req.wdata[tic_pkg::BIT_ACC_A_OVF_EN];
          next_state.acc_b_overflow_trap_en = req.wdata[tic_pkg::BIT_ACC_B_OVF_EN];
          next_state.catastrophic_trap_en   = req.wdata[tic_pkg::BIT_CAT_EN];
        end
        tic_pkg::OFS_GLOBAL_CONTROL: begin
          next_state.alt_vector_select = req.wdata[tic_pkg::BIT_ALT_VECTOR];
          next_state.edge_polarity     = req.wdata[2:0];
        end
        tic_pkg::OFS_PRIORITY: begin
          // The level is frozen against software while nesting is off.
          if (!state.nesting_off) begin
            next_state.cpu_priority_level = req.wdata[tic_pkg::PRIO_W-1:0];
          end
        end
        default: begin
          next_state.cpu_priority_level = state.cpu_priority_level;
        end
      endcase
    end

    // Register reads answer in the next cycle only.
    if (req.rd) begin
      case (req.addr)
        tic_pkg::OFS_TRAP_CONTROL:   next_state.rdata = trap_word;
        tic_pkg::OFS_GLOBAL_CONTROL: next_state.rdata = global_word;
        tic_pkg::OFS_FLAG_WORD0:     next_state.rdata = flag_word0;
        tic_pkg::OFS_PRIORITY:       next_state.rdata = priority_word;
        default:                     next_state.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Everything clears at reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                    <= '0;
      state.edge_polarity      <= tic_pkg::RST_EDGE_POLARITY;
      state.cpu_priority_level <= tic_pkg::RST_PRIORITY;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  // Nesting and vector table controls steer the core.
  assign nesting_off_o        = state.nesting_off;
  assign alt_vector_select_o  = state.alt_vector_select;
  assign cpu_priority_level_o = state.cpu_priority_level;
  assign trap_o               = state.trap;
  assign ext_edge_o           = state.ext_edge;
  assign reg_rdata_o          = state.rdata;

endmodule

// ---- test/tic_periph_model.sv ----
// Peripheral request sources facing the flag word.
// Assumes the bench commands one-cycle pulses on the system clock.
`timescale 1ns/10ps
module tic_periph_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [13:0] fire_i,
  output logic      [13:0] req_o
);
  // Each commanded pulse leaves the peripheral one cycle later, one cycle wide.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 14'h0000;
    end else begin
      req_o <= fire_i;
    end
  end
endmodule

// ---- test/tic_asserts.sv ----
// Checker for the trap and interrupt control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module tic_asserts (
  input wire logic                     clk_sys_i,
  input wire logic                     rst_n_i,
  input wire logic [1:0]               reg_addr_i,
  input wire logic [15:0]              reg_wdata_i,
  input wire logic                     reg_wr_i,
  input wire logic                     reg_rd_i,
  input wire logic [15:0]              reg_rdata_o,
  input wire tic_pkg::tic_trap_event_t trap_event_i,
  input wire logic                     timed_irq_block_i,
  input wire logic                     timer_a_i,
  input wire logic                     nesting_off_o,
  input wire logic                     alt_vector_select_o,
  input wire logic [2:0]               cpu_priority_level_o,
  input wire logic                     trap_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] en;
  // Shadow of the three overflow trap enables, kept from software writes.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 2'h0) begin
      en <= reg_wdata_i[10:8];
    end
  end
  sequence s_timer_read;
    timer_a_i ##1 (reg_rd_i && reg_addr_i == 2'h2);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_nest_write: assert property (reg_wr_i && reg_addr_i == 2'h0 |=> nesting_off_o == $past(reg_wdata_i[15]))
    else $error("nesting control does not follow the write");
  chk_alt_write: assert property (reg_wr_i && reg_addr_i == 2'h1 |=> alt_vector_select_o == $past(reg_wdata_i[15]))
    else $error("vector table select does not follow the write");
  chk_unused_zero: assert property (reg_rd_i |=> !(($past(reg_addr_i) == 2'h0 && reg_rdata_o[0])
    || ($past(reg_addr_i) == 2'h1 && |reg_rdata_o[13:3]) || ($past(reg_addr_i) == 2'h2 && reg_rdata_o[15])))
    else $error("unimplemented bit read as one");
  chk_block_mirror: assert property (reg_rd_i && reg_addr_i == 2'h1 |=> reg_rdata_o[14] == $past(timed_irq_block_i, 2))
    else $error("timed block status bit wrong");
  chk_trap_fixed: assert property ((|trap_event_i[5:0]) |=> trap_o)
    else $error("unconditional trap gave no trap pulse");
  chk_trap_cause: assert property (trap_o |-> $past(trap_event_i) != 10'h000)
    else $error("trap pulse without an event");
  chk_ovf_gate: assert property ((trap_event_i == 10'h200 && !en[2]) || (trap_event_i == 10'h100 && !en[1]) |=> !trap_o)
    else $error("disabled overflow trap was taken");
  chk_cat_gate: assert property ((trap_event_i == 10'h080 || trap_event_i == 10'h040) && !en[0] |=> !trap_o)
    else $error("disabled catastrophic trap was taken");
  chk_prio_lock: assert property (nesting_off_o && reg_wr_i && reg_addr_i == 2'h3 |=> $stable(cpu_priority_level_o))
    else $error("priority level changed while locked");
  chk_timer_flag: assert property (s_timer_read |=> reg_rdata_o[3])
    else $error("timer A flag not read as set");
endmodule
bind tic_trap_and_interrupt_control tic_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .trap_event_i(trap_event_i), .timed_irq_block_i(timed_irq_block_i),
  .timer_a_i(timer_a_i), .nesting_off_o(nesting_off_o), .alt_vector_select_o(alt_vector_select_o),
  .cpu_priority_level_o(cpu_priority_level_o), .trap_o(trap_o));

// ---- test/tic_trap_and_interrupt_control_tb_top.sv ----
// Self-checking bench for the trap and interrupt control block.
// Assumes the peripheral model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tic_trap_and_interrupt_control_tb_top;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_n_i   = 1'b0;
  logic [1:0]               reg_addr  = 2'h0;
  logic [15:0]              reg_wdata = 16'h0000;
  logic                     reg_wr    = 1'b0;
  logic                     reg_rd    = 1'b0;
  logic [15:0]              reg_rdata;
  tic_pkg::tic_trap_event_t ev        = '0;
  logic                     timed     = 1'b0;
  logic [13:0]              fire      = 14'h0000;
  logic [13:0]              req;
  logic [2:0]               pins      = 3'h0;
  logic [2:0]               edges;
  logic [2:0]               edge_seen = 3'h0;
  logic                     nest;
  logic                     alt;
  logic [2:0]               prio;
  logic                     trap;
  int                       fail_count  = 0;
  int                       checks_done = 0;
  logic [15:0]              tx [10] = '{16'h0002, 16'h0004, 16'h0008, 16'h0020, 16'h0050,
                                        16'h0090, 16'h0810, 16'h1010, 16'h2010, 16'h4010};
  tic_periph_model u_src (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fire_i(fire), .req_o(req));
  tic_trap_and_interrupt_control DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .trap_event_i(ev), .timed_irq_block_i(timed), .dma_ch1_done_i(req[13]), .converter1_done_i(req[12]),
    .uart_a_tx_i(req[11]), .uart_a_rx_i(req[10]), .spi_a_event_i(req[9]), .spi_a_error_i(req[8]),
    .timer_c_i(req[7]), .timer_b_i(req[6]), .compare_ch2_i(req[5]), .capture_ch2_i(req[4]),
    .dma_ch0_done_i(req[3]), .timer_a_i(req[2]), .compare_ch1_i(req[1]), .capture_ch1_i(req[0]),
    .ext_pin_i(pins), .nesting_off_o(nest), .alt_vector_select_o(alt), .cpu_priority_level_o(prio),
    .trap_o(trap), .ext_edge_o(edges));
  // Free-running clock.
  always #20 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] ad, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [1:0] ad, input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1 chk("read", reg_rdata, e);
  endtask
  task automatic pulse(input logic [9:0] v, input logic t);
    @(posedge clk_sys_i);
    ev <= v;
    @(posedge clk_sys_i);
    ev <= '0;
    #1 chk("trap", {15'h0000, trap}, {15'h0000, t});
  endtask
  task automatic edge_watch(input logic [2:0] p);
    @(posedge clk_sys_i);
    pins      <= p;
    edge_seen = 3'h0;
    repeat (8) begin
      @(posedge clk_sys_i);
      #1 edge_seen = edge_seen | edges;
    end
  endtask
  task automatic t_traps;
    wr(2'h0, 16'h8701);
    rchk(2'h0, 16'h8700);
    chk("nest", {15'h0000, nest}, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      wr(2'h0, 16'h0700);
      pulse(10'h001 << i, 1'b1);
      rchk(2'h0, tx[i] | 16'h0700);
    end
    wr(2'h0, 16'h0000);
    for (int i = 6; i < 10; i++) begin
      pulse(10'h001 << i, 1'b0);
      rchk(2'h0, 16'h0000);
    end
  endtask
  task automatic t_flags;
    for (int i = 0; i < 14; i++) begin
      wr(2'h2, 16'h8000);
      @(posedge clk_sys_i);
      fire <= 14'h0001 << i;
      @(posedge clk_sys_i);
      fire <= 14'h0000;
      rchk(2'h2, 16'h0002 << i);
    end
    wr(2'h2, 16'h8000);
    rchk(2'h2, 16'h0000);
    @(posedge clk_sys_i);
    fire <= 14'h0004;
    @(posedge clk_sys_i);
    fire      <= 14'h0000;
    reg_addr  <= 2'h2;
    reg_wdata <= 16'h0000;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rchk(2'h2, 16'h0008);
    wr(2'h2, 16'h0000);
  endtask
  task automatic t_global;
    @(posedge clk_sys_i);
    timed <= 1'b1;
    wr(2'h1, 16'hffff);
    rchk(2'h1, 16'hc007);
    chk("alt", {15'h0000, alt}, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      wr(2'h1, (k == 0) ? 16'h0007 : 16'h0000);
      timed <= 1'b0;
      rchk(2'h1, (k == 0) ? 16'h0007 : 16'h0000);
      edge_watch(3'h7);
      chk("rise", {13'h0000, edge_seen}, (k == 0) ? 16'h0000 : 16'h0007);
      edge_watch(3'h0);
      chk("fall", {13'h0000, edge_seen}, (k == 0) ? 16'h0007 : 16'h0000);
    end
    chk("alt", {15'h0000, alt}, 16'h0000);
    rchk(2'h2, 16'h0001);
  endtask
  task automatic t_prio;
    wr(2'h3, 16'h0005);
    rchk(2'h3, 16'h0005);
    wr(2'h0, 16'h8000);
    wr(2'h3, 16'h0002);
    rchk(2'h3, 16'h0005);
    chk("prio", {13'h0000, prio}, 16'h0005);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values first, then each scenario in turn.
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(i[1:0], 16'h0000);
    t_traps();
    t_flags();
    t_global();
    t_prio();
    final_report();
  end
  // Watchdog well beyond the expected run of under two thousand cycles.
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule
